/* File: hdl/disp_spi_pkg.sv */
// Shared constants for the display serial command port
package disp_spi_pkg;
  // ------------------------------------------------------------
  // Command bytes and frame layout
  // ------------------------------------------------------------
  localparam logic [7:0] FULL_SCREEN_UPDATE_CMD  = 8'h18;
  localparam logic [7:0] PARTIAL_ROWS_UPDATE_CMD = 8'h19;
  localparam logic [7:0] SLEEP_CMD               = 8'h20;
  localparam logic [7:0] SOFT_RESET_CMD          = 8'h21;
  localparam int         STATUS_BUSY_BIT         = 7;
  localparam int         OUT_PIPE_DEPTH          = 3;
  localparam int         IMG_ADDR_W              = 15;  // 32 KB memory
  localparam logic [2:0] OUT_PIPE_RESET          = 3'h7;
  // ------------------------------------------------------------
  // Timing, 50 ns system clock
  // ------------------------------------------------------------
  localparam int SYS_CLK_NS    = 50;
  localparam int RESET_SEQ_NS  = 10000;
  localparam int FIXED_OP_NS   = 2000;
  localparam int RESET_SEQ_CYC =
    (RESET_SEQ_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int FIXED_OP_CYC  =
    (FIXED_OP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int TIMER_W       = 16;
endpackage

/* File: hdl/display_spi_command_port.sv */
// Serial command port of a bistable graphic display controller
`timescale 1ns/100ps

module display_spi_command_port
  import disp_spi_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_SEQ_CYC,
  parameter int OP_CYCLES    = FIXED_OP_CYC
) (
  // System clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // Serial link pins
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  si_i,
  output logic                       so_o,
  output logic                       so_oe_n_o,
  // Control pins
  input  wire logic                  reset_pin_n_i,
  output logic                       reset_pullup_en_o,
  output logic                       busy_o,
  // Packet stream to the command decoder
  output logic [7:0]                 rx_byte_o,
  output logic                       rx_valid_o,
  output logic                       rx_first_o,
  // Panel and power control
  output logic                       panel_update_o,
  output logic                       partial_update_o,
  output logic [IMG_ADDR_W-1:0]      update_addr_o,
  input  wire logic                  panel_done_i,
  output logic                       sleep_mode_o,
  output logic                       bias_en_o
);

  typedef enum logic [2:0] {
    ST_HOLD, ST_INIT, ST_IDLE, ST_RECV, ST_EXEC, ST_UPDATE
  } state_t;

  // ------------------------------------------------------------
  // Link domain: receive shifter on falling edges
  // ------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [7:0] rx_hold;
  logic       rx_tog;

  // Counter cleared while deselected since the clock may stop
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt  <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[5:0], si_i};
    end
  end

  // Completed byte held for eight link clocks, toggle marks it.
  // The toggle needs a known start or the crossing never settles.
  always_ff @(negedge sck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_hold <= 8'h00;
      rx_tog  <= 1'b0;
    end else if (!cs_n_i && bit_cnt == 3'h7) begin
      rx_hold <= {rx_shift, si_i};
      rx_tog  <= ~rx_tog;
    end
  end

  // ------------------------------------------------------------
  // Link domain: status output on rising edges
  // ------------------------------------------------------------
  logic [2:0] tx_cnt;
  logic [2:0] out_pipe;
  logic       busy_meta;
  logic       busy_link;

  // Busy level crossing into the link clock; selection itself counts
  // as busy, so a level left stale since the last frame is not trusted
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      busy_meta <= 1'b1;
      busy_link <= 1'b1;
    end else begin
      busy_meta <= busy_o;
      busy_link <= busy_meta;
    end
  end

  // Status bit walks three byte slots before reaching the pin
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_cnt    <= 3'h0;
      out_pipe  <= OUT_PIPE_RESET;
      so_o      <= 1'b0;
      so_oe_n_o <= 1'b1;
    end else begin
      tx_cnt    <= tx_cnt + 3'h1;
      so_oe_n_o <= 1'b0;
      if (tx_cnt == 3'h0) begin
        out_pipe <= {out_pipe[1:0], busy_link};
        so_o     <= out_pipe[2];
      end else begin
        so_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // System domain synchronisers
  // ------------------------------------------------------------
  logic cs_meta, cs_hi, cs_hi_d;
  logic rst_meta, rst_pin;
  logic tog_meta, tog_s, tog_d;

  always_ff @(posedge sys_clk_i) begin
    cs_meta  <= cs_n_i;
    cs_hi    <= cs_meta;
    cs_hi_d  <= cs_hi;
    rst_meta <= reset_pin_n_i;
    rst_pin  <= rst_meta;
    tog_meta <= rx_tog;
    tog_s    <= tog_meta;
    tog_d    <= tog_s;
  end

  wire cs_fall  = cs_hi_d && !cs_hi;
  wire cs_rise  = !cs_hi_d && cs_hi;
  wire byte_evt = tog_s ^ tog_d;

  // ------------------------------------------------------------
  // Packet bookkeeping
  // ------------------------------------------------------------
  state_t        state, next_state;
  logic [7:0]    cmd;
  logic [1:0]    arg_cnt;
  logic          have_cmd;
  logic [IMG_ADDR_W-1:0] addr;
  logic [TIMER_W-1:0]    timer;

  wire is_update = (cmd == FULL_SCREEN_UPDATE_CMD) ||
                   (cmd == PARTIAL_ROWS_UPDATE_CMD);
  wire is_sleep  = (cmd == SLEEP_CMD);
  wire is_reset  = (cmd == SOFT_RESET_CMD);
  wire timer_end = (timer == '0);
  wire pkt_end   = (state == ST_RECV) && cs_rise;

  // Next state; the reset pin overrides everything
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:   next_state = ST_INIT;
      ST_INIT:   if (timer_end) next_state = ST_IDLE;
      ST_IDLE:   if (cs_fall) next_state = ST_RECV;
      ST_RECV: begin
        if (cs_rise) begin
          if (!have_cmd) next_state = ST_IDLE;
          else if (is_reset) next_state = ST_INIT;
          else if (is_update) next_state = ST_UPDATE;
          else next_state = ST_EXEC;
        end
      end
      ST_EXEC:   if (timer_end) next_state = ST_IDLE;
      ST_UPDATE: if (panel_done_i) next_state = ST_IDLE;
      default:   next_state = ST_HOLD;
    endcase
    if (!rst_pin) next_state = ST_HOLD;
  end

  // State register and timer, sized for the longest wait
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= ST_INIT;
      timer <= TIMER_W'(RESET_CYCLES - 1);
    end else begin
      state <= next_state;
      if (next_state == ST_INIT && state != ST_INIT)
        timer <= TIMER_W'(RESET_CYCLES - 1);
      else if (pkt_end)
        timer <= TIMER_W'(OP_CYCLES - 1);
      else if (!timer_end)
        timer <= timer - TIMER_W'(1);
    end
  end

  // Command and start address capture; bytes after the second argument are ignored
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || state != ST_RECV) begin
      have_cmd <= 1'b0;
      arg_cnt  <= 2'h0;
      cmd      <= 8'h00;
      addr     <= '0;
    end else if (byte_evt) begin
      if (!have_cmd) begin
        cmd      <= rx_hold;
        have_cmd <= 1'b1;
      end else if (arg_cnt != 2'h2) begin
        addr    <= IMG_ADDR_W'({addr, rx_hold});
        arg_cnt <= arg_cnt + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      busy_o            <= 1'b1;
      reset_pullup_en_o <= 1'b0;
      rx_byte_o         <= 8'h00;
      rx_valid_o        <= 1'b0;
      rx_first_o        <= 1'b0;
      panel_update_o    <= 1'b0;
      partial_update_o  <= 1'b0;
      update_addr_o     <= '0;
      sleep_mode_o      <= 1'b1;
      bias_en_o         <= 1'b0;
    end else begin
      reset_pullup_en_o <= 1'b1;
      busy_o     <= (next_state != ST_IDLE);
      rx_valid_o <= (state == ST_RECV) && byte_evt;
      rx_first_o <= (state == ST_RECV) && byte_evt && !have_cmd;
      if (byte_evt)
        rx_byte_o <= rx_hold;
      // Panel only changes through an update command
      panel_update_o <= pkt_end && have_cmd && is_update;
      if (pkt_end && have_cmd && is_update) begin
        partial_update_o <= (cmd == PARTIAL_ROWS_UPDATE_CMD);
        update_addr_o    <= addr;
      end
      // Sleep keeps memory; only the bias supply is dropped
      if (state == ST_INIT && next_state == ST_IDLE) begin
        sleep_mode_o <= 1'b1;
        bias_en_o    <= 1'b0;
      end else if (pkt_end && have_cmd && is_sleep) begin
        sleep_mode_o <= 1'b1;
        bias_en_o    <= 1'b0;
      end else if (pkt_end && have_cmd && is_update) begin
        sleep_mode_o <= 1'b0;
        bias_en_o    <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions, system domain
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_busy_recv;
    (state == ST_RECV && !cs_rise) |=> busy_o;
  endproperty
  a_busy_recv: assert property (p_busy_recv)
    else $error("busy dropped while selected");

  property p_pin_hold;
    !rst_pin |=> (state == ST_HOLD) ##1 busy_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset pin did not hold controller");

  property p_sleep_after_init;
    (state == ST_INIT && next_state == ST_IDLE) |=>
      sleep_mode_o && !busy_o;
  endproperty
  a_sleep_after_init: assert property (p_sleep_after_init)
    else $error("not asleep after reset sequence");

  property p_idle_busy;
    (state == ST_IDLE) |-> !busy_o || $past(state) != ST_IDLE;
  endproperty
  a_idle_busy: assert property (p_idle_busy)
    else $error("busy high while idle");

  property p_bias_off;
    sleep_mode_o |-> !bias_en_o;
  endproperty
  a_bias_off: assert property (p_bias_off)
    else $error("bias on in sleep");

  property p_update_cause;
    panel_update_o |-> $past(pkt_end) && $past(is_update);
  endproperty
  a_update_cause: assert property (p_update_cause)
    else $error("panel update without command");

  // Raw pin: the synchronised copy lags the asynchronous release
  property p_hiz;
    cs_n_i |-> so_oe_n_o;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven while deselected");

  property p_ignore;
    cs_n_i |-> (bit_cnt == 3'h0);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("bits counted while deselected");

  // ------------------------------------------------------------
  // Assertions, link domain
  // ------------------------------------------------------------
  property p_byte_pair;
    @(posedge sck_i) disable iff (cs_n_i) tx_cnt == bit_cnt;
  endproperty
  a_byte_pair: assert property (p_byte_pair)
    else $error("output byte out of step with input");

  property p_status_bit;
    @(posedge sck_i) disable iff (cs_n_i)
      (tx_cnt == 3'h0) |=> so_o == $past(out_pipe[2]);
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("status bit not from pipeline");

  property p_low_zero;
    @(posedge sck_i) disable iff (cs_n_i)
      (tx_cnt != 3'h0) |=> !so_o;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("undefined status bit set");

  c_update: cover property (panel_update_o ##[1:400] !busy_o);
  c_soft_reset: cover property (pkt_end && is_reset);
  c_sleep: cover property (pkt_end && is_sleep);
  c_pin_reset: cover property ($rose(rst_pin));

endmodule

/* File: testbench/host_master.sv */
// Serial bus master model that faces the display command port
`timescale 1ns/100ps
module host_master (
  // Link pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  logic so_last;
  wire  so_pin;
  // A released line keeps no value: show the inverse of the last bit
  assign so_pin = so_oe_n_i ? ~so_last : so_i;
  always @(so_i) if (!so_oe_n_i) so_last = so_i;
  // Clock stands low outside frames
  // Deselect first so the port's link logic starts cleared
  initial begin
    cs_n_o <= 1'b1;
    sck_o <= 1'b0;
    si_o <= 1'b0;
    so_last = 1'b0;
  end
  // ----------------------------------------
  // Frame tasks, 160 ns link period
  // ----------------------------------------
  // New data just after each rise, output taken at each fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b1;
      si_o <= tx[i];
      #80;
      sck_o = 1'b0;
      rx[i] = so_pin;
      #80;
    end
  endtask
  // Spacing before every select covers both gap limits
  task automatic select_dev();
    #400;
    cs_n_o = 1'b0;
    #80;
  endtask
  // Deselect right after the packet, no completion watching
  task automatic release_dev();
    #80;
    cs_n_o = 1'b1;
  endtask
endmodule

/* File: testbench/tb_display_spi_command_port.sv */
// Self-checking bench for the display serial command port
`timescale 1ns/100ps
module tb_display_spi_command_port;
  import disp_spi_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  reset_n;
  logic                  reset_pin_n = 1'b1;
  logic                  panel_done = 1'b0;
  wire                   sck, cs_n, si, so, so_oe_n, pullup_en, busy;
  wire                   rx_valid, rx_first, panel_update, partial_update;
  wire                   sleep_mode, bias_en;
  wire [7:0]             rx_byte;
  wire [IMG_ADDR_W-1:0]  update_addr;
  int                    failures = 0;
  int                    check_count = 0;
  logic [8:0]            exp_q[$];
  logic [8:0]            e;
  logic [7:0]            so_byte, a1, a2;
  always #25 sys_clk = ~sys_clk;
  // Short counts keep the run brief
  display_spi_command_port #(.RESET_CYCLES(4), .OP_CYCLES(4)) dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
    .reset_pin_n_i(reset_pin_n), .reset_pullup_en_o(pullup_en),
    .busy_o(busy), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .rx_first_o(rx_first), .panel_update_o(panel_update),
    .partial_update_o(partial_update), .update_addr_o(update_addr),
    .panel_done_i(panel_done), .sleep_mode_o(sleep_mode),
    .bias_en_o(bias_en));
  host_master mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_n_i(so_oe_n));
  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk1(input string what, input logic ex, input logic ac);
    check_count++;
    if (ac !== ex) begin
      failures++;
      $display("CHECK FAILED %s exp %b got %b", what, ex, ac);
    end
  endtask
  task automatic chkv(input string what, input logic [15:0] ex, ac);
    check_count++;
    if (ac !== ex) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", what, ex, ac);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait on busy (sel 0) or the update pulse (sel 1)
  task automatic wait_for(input bit sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? panel_update : busy) !== lvl) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 3000) begin
        chk1("bounded wait", lvl, ~lvl);
        close_out();
      end
    end
  endtask
  // ----------------------------------------
  // Driver side: note each byte, then shift it
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input logic first);
    exp_q.push_back({first, b});
    mst.xfer(b, so_byte);
    chkv("status byte", 16'h0080, {8'h00, so_byte});
  endtask
  task automatic cmd_only(input logic [7:0] c);
    mst.select_dev();
    send(c, 1'b1);
    mst.release_dev();
  endtask
  // Update packet with a spare argument, up to the start pulse
  task automatic update(input bit part);
    a1 = 8'($urandom());
    a2 = 8'($urandom());
    mst.select_dev();
    send(part ? PARTIAL_ROWS_UPDATE_CMD : FULL_SCREEN_UPDATE_CMD, 1'b1);
    send(a1, 1'b0);
    send(a2, 1'b0);
    send(8'($urandom()), 1'b0);
    chk1("busy while selected", 1'b1, busy);
    mst.release_dev();
    wait_for(1, 1'b1);
    chkv("start address", {a1, a2} & 16'h7FFF, 16'(update_addr));
    chk1("partial kind", part, partial_update);
    chk1("bias on for update", 1'b1, bias_en);
  endtask
  // Monitor: every received byte answers the oldest note
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk1("stray byte", 1'b0, 1'b1);
      else begin
        e = exp_q.pop_front();
        chkv("rx byte", {7'h00, e}, {7'h00, rx_first, rx_byte});
      end
    end
    if (panel_update === 1'b1) chk1("update while selected", 1'b1, cs_n);
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n <= 1'b0;
    void'($urandom(19596));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk1("busy in reset", 1'b1, busy);
    wait_for(0, 1'b0);
    chk1("asleep after reset", 1'b1, sleep_mode);
    chk1("pull-up on", 1'b1, pullup_en);
    chk1("so released", 1'b1, so_oe_n);
    mst.xfer(8'hA5, so_byte);
    // Both update kinds, each held busy until the panel finishes
    for (int k = 0; k < 2; k++) begin
      update(k[0]);
      repeat (5) @(posedge sys_clk);
      chk1("busy until panel done", 1'b1, busy);
      panel_done <= 1'b1;
      @(posedge sys_clk);
      panel_done <= 1'b0;
      wait_for(0, 1'b0);
    end
    cmd_only(SLEEP_CMD);
    wait_for(0, 1'b0);
    chk1("sleep command", 1'b1, sleep_mode);
    chk1("bias off asleep", 1'b0, bias_en);
    // Reset pin in mid-update: panel completion must be ignored
    update(1'b0);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    panel_done <= 1'b1;
    @(posedge sys_clk);
    panel_done <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk1("busy held in pin reset", 1'b1, busy);
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    wait_for(0, 1'b0);
    chk1("asleep after pin reset", 1'b1, sleep_mode);
    chk1("bias off after pin reset", 1'b0, bias_en);
    // Soft reset runs the same sequence
    update(1'b1);
    @(posedge sys_clk);
    panel_done <= 1'b1;
    @(posedge sys_clk);
    panel_done <= 1'b0;
    wait_for(0, 1'b0);
    cmd_only(SOFT_RESET_CMD);
    wait_for(0, 1'b0);
    chk1("asleep after soft reset", 1'b1, sleep_mode);
    repeat (10) @(posedge sys_clk);
    chkv("bytes left", 16'h0000, 16'(exp_q.size()));
    close_out();
  end
endmodule
